/* hdl/drb_map.svh */
/*
  offsets, field positions and constant values of the extended diagnostic record.
  assumes: included by bare name from design files; definitions only.
*/
`ifndef DRB_MAP_SVH
`define DRB_MAP_SVH
`define DRB_OFS_BASIC 4'h0
`define DRB_OFS_CHTYPE 4'h4
`define DRB_OFS_BITS_PER_CH 4'h5
`define DRB_OFS_CH_COUNT 4'h6
`define DRB_OFS_GROUP_ERR 4'h7
`define DRB_OFS_LOST_IN_A 4'h8
`define DRB_OFS_LOST_IN_B 4'h9
`define DRB_OFS_LOST_IN_C 4'hA
`define DRB_OFS_LOST_IN_D 4'hB
`define DRB_OFS_LOST_CNT0 4'hC
`define DRB_OFS_LOST_CNT1 4'hD
`define DRB_OFS_LOST_CNT2 4'hE
`define DRB_OFS_LOST_CNT3 4'hF
`define DRB_CHTYPE_DIG_IN 7'h70
`define DRB_CHTYPE_ANA_IN 7'h71
`define DRB_CHTYPE_DIG_OUT 7'h72
`define DRB_CHTYPE_ANA_OUT 7'h73
`define DRB_CHTYPE_ANA_IO 7'h74
`define DRB_MORE_TYPES_POS 7
`define DRB_BITS_PER_CH 8'h08
`define DRB_CH_COUNT 8'h08
`define DRB_LOST_BIT_POS 6
`define DRB_CNT_GATE_CLOSED 0
`define DRB_CNT_GATE_OPENED 1
`define DRB_CNT_OVERFLOW 2
`define DRB_CNT_COMPARE 3
`define DRB_RECORD_RESET 8'h00
`endif

/* hdl/drb_pkg.sv */
/*
  types shared by the diagnostic record builder.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package drb_pkg;
  typedef logic [7:0] drb_byte_t;
  typedef logic [3:0] drb_idx_t;
  typedef enum logic [0:0] {drb_idle, drb_held} drb_state_t;
endpackage

/* hdl/drb_evt_if.sv */
/*
  interface carrying one round of lost-event flags between modules.
  assumes: single clock; events are one-cycle strobes.
*/
`timescale 1ns/10ps
`default_nettype none
interface drb_evt_if;
  logic [15:0] in_lost;
  logic [15:0] cnt_lost;
  logic any_new;
  modport src (output in_lost, output cnt_lost, output any_new);
  modport dst (input in_lost, input cnt_lost, input any_new);
endinterface
`default_nettype wire

/* hdl/drb_lost_detect.sv */
/*
  detects process events lost because the previous one is still serviced.
  assumes: event and busy inputs synchronous to mclk; rst_sync_n already released.
*/
`timescale 1ns/10ps
`default_nettype none
module drb_lost_detect (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_sync_n,
  // per-event strobes and service state
  input wire logic [15:0] in_event,
  input wire logic [15:0] in_busy,
  input wire logic [15:0] cnt_event,
  input wire logic [15:0] cnt_busy,
  // detected losses
  drb_evt_if.src evt
);
  logic [15:0] in_lost_d;
  logic [15:0] in_lost_q;
  logic [15:0] cnt_lost_d;
  logic [15:0] cnt_lost_q;
  // ----------------------------------------
  // recurrence while serviced
  // ----------------------------------------
  always_comb begin
    in_lost_d = in_event & in_busy; // RQ11
    cnt_lost_d = cnt_event & cnt_busy; // RQ11
  end
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      in_lost_q <= 16'h0000;
      cnt_lost_q <= 16'h0000;
    end else begin
      in_lost_q <= in_lost_d;
      cnt_lost_q <= cnt_lost_d;
    end
  end
  assign evt.in_lost = in_lost_q;
  assign evt.cnt_lost = cnt_lost_q;
  assign evt.any_new = |{in_lost_q, cnt_lost_q};
endmodule
`default_nettype wire

/* hdl/drb_record.sv */
/*
  builds the 16-byte extended diagnostic record and serves byte reads.
  the record is captured on the first lost event and held until released;
  later losses only merge into the lost-event bytes and the lost flag.
  assumes: basic record bytes and group errors come from the module core;
  software reads one byte per cycle by index; single clock mclk.
*/
// How it works
// (RQ1) record is basic four bytes plus twelve
// (RQ2) byte 4 low seven bits: type 70h
// (RQ3) byte 4 bit 7: more types flag
// (RQ4) byte 5 is eight diagnostic bits
// (RQ5) byte 6 is eight channels
// (RQ6) byte 7 flags input groups, counters
// (RQ7) bytes 8 to 15 flag lost events
// (RQ8) inputs on even bits, odd bits zero
// (RQ9) counter byte: closed, opened, overflow, compare
// (RQ10) bytes 12 to 15 follow counters 0-3
// (RQ11) loss is recurrence while still serviced
// (RQ12) basic byte 3 bit 6 on loss
// (RQ13) contents frozen while software reads; code freezes bytes 0 to 7 while held, bytes 8 to 15 still merge losses
`timescale 1ns/10ps
`default_nettype none
`include "drb_map.svh"
module drb_record (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // basic record and module state
  input wire logic [31:0] basic_in,
  input wire logic [7:0] group_err_in,
  input wire logic more_types,
  // process events: 16 inputs, 4 counters x 4 kinds
  input wire logic [15:0] in_event,
  input wire logic [15:0] in_busy,
  input wire logic [15:0] cnt_event,
  input wire logic [15:0] cnt_busy,
  // software read port
  input wire logic rd_en,
  input wire logic [3:0] rd_idx,
  output logic [7:0] rd_data,
  input wire logic rec_release,
  // status
  output logic diag_irq,
  output logic rec_held
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  // reset release chain
  logic rst_s1_d;
  logic rst_s1_q;
  logic rst_sync_d;
  logic rst_sync_n;

  // losses seen by the detector
  drb_evt_if evt ();

  // hold state and interrupt pulse
  drb_pkg::drb_state_t st_d;
  drb_pkg::drb_state_t st_q;
  logic irq_d;
  logic irq_q;

  // record image, one byte per offset
  drb_pkg::drb_byte_t rec_d [16];
  drb_pkg::drb_byte_t rec_q [16];

  // read data
  logic [7:0] rd_d;
  logic [7:0] rd_q;

  // ----------------------------------------
  // byte builders
  // ----------------------------------------

  // spread four flags onto even bits
  function automatic drb_pkg::drb_byte_t even_spread(input logic [3:0] f);
    even_spread = {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]}; // RQ8
  endfunction

  // one counter's flags, each kind on its own even bit
  function automatic drb_pkg::drb_byte_t cnt_spread(input logic [3:0] f);
    drb_pkg::drb_byte_t v;
    v = 8'h00;
    v[2 * `DRB_CNT_GATE_CLOSED] = f[`DRB_CNT_GATE_CLOSED]; // RQ9
    v[2 * `DRB_CNT_GATE_OPENED] = f[`DRB_CNT_GATE_OPENED]; // RQ9
    v[2 * `DRB_CNT_OVERFLOW] = f[`DRB_CNT_OVERFLOW]; // RQ9
    v[2 * `DRB_CNT_COMPARE] = f[`DRB_CNT_COMPARE]; // RQ9
    return v;
  endfunction

  // channel type with the more-types flag on top
  function automatic drb_pkg::drb_byte_t type_byte(input logic more);
    drb_pkg::drb_byte_t v;
    v = {1'b0, `DRB_CHTYPE_DIG_IN}; // RQ2
    v[`DRB_MORE_TYPES_POS] = more; // RQ3
    return v;
  endfunction

  // basic byte with the lost flag raised
  function automatic drb_pkg::drb_byte_t mark_lost(input drb_pkg::drb_byte_t b);
    drb_pkg::drb_byte_t v;
    v = b;
    v[`DRB_LOST_BIT_POS] = 1'b1; // RQ12
    return v;
  endfunction

  // group errors: inputs low nibble, counters high
  function automatic drb_pkg::drb_byte_t group_byte(
    input logic [3:0] in_grp,
    input logic [3:0] cnt_grp
  );
    return {cnt_grp, in_grp}; // RQ6
  endfunction

  // one lost-event byte by record offset
  function automatic drb_pkg::drb_byte_t lost_byte(
    input drb_pkg::drb_idx_t ofs,
    input logic [15:0] in_l,
    input logic [15:0] cnt_l
  );
    drb_pkg::drb_byte_t v;
    v = 8'h00;
    case (ofs)
      `DRB_OFS_LOST_IN_A: v = even_spread(in_l[3:0]); // RQ8
      `DRB_OFS_LOST_IN_B: v = even_spread(in_l[7:4]); // RQ8
      `DRB_OFS_LOST_IN_C: v = even_spread(in_l[11:8]); // RQ8
      `DRB_OFS_LOST_IN_D: v = even_spread(in_l[15:12]); // RQ8
      `DRB_OFS_LOST_CNT0: v = cnt_spread(cnt_l[3:0]); // RQ10
      `DRB_OFS_LOST_CNT1: v = cnt_spread(cnt_l[7:4]); // RQ10
      `DRB_OFS_LOST_CNT2: v = cnt_spread(cnt_l[11:8]); // RQ10
      `DRB_OFS_LOST_CNT3: v = cnt_spread(cnt_l[15:12]); // RQ10
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // record byte picked by read index
  function automatic drb_pkg::drb_byte_t read_pick(
    input drb_pkg::drb_idx_t idx,
    input drb_pkg::drb_byte_t r [16]
  );
    drb_pkg::drb_byte_t v;
    v = 8'h00;
    case (idx)
      `DRB_OFS_BASIC: v = r[0]; // RQ1
      `DRB_OFS_BASIC + 4'h1: v = r[1]; // RQ1
      `DRB_OFS_BASIC + 4'h2: v = r[2]; // RQ1
      `DRB_OFS_BASIC + 4'h3: v = r[3]; // RQ1
      `DRB_OFS_CHTYPE: v = r[`DRB_OFS_CHTYPE]; // RQ2
      `DRB_OFS_BITS_PER_CH: v = r[`DRB_OFS_BITS_PER_CH]; // RQ4
      `DRB_OFS_CH_COUNT: v = r[`DRB_OFS_CH_COUNT]; // RQ5
      `DRB_OFS_GROUP_ERR: v = r[`DRB_OFS_GROUP_ERR]; // RQ6
      `DRB_OFS_LOST_IN_A: v = r[`DRB_OFS_LOST_IN_A]; // RQ8
      `DRB_OFS_LOST_IN_B: v = r[`DRB_OFS_LOST_IN_B]; // RQ8
      `DRB_OFS_LOST_IN_C: v = r[`DRB_OFS_LOST_IN_C]; // RQ8
      `DRB_OFS_LOST_IN_D: v = r[`DRB_OFS_LOST_IN_D]; // RQ8
      `DRB_OFS_LOST_CNT0: v = r[`DRB_OFS_LOST_CNT0]; // RQ10
      `DRB_OFS_LOST_CNT1: v = r[`DRB_OFS_LOST_CNT1]; // RQ10
      `DRB_OFS_LOST_CNT2: v = r[`DRB_OFS_LOST_CNT2]; // RQ10
      `DRB_OFS_LOST_CNT3: v = r[`DRB_OFS_LOST_CNT3]; // RQ10
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_comb begin
    rst_s1_d = 1'b1;
    rst_sync_d = rst_s1_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q <= rst_s1_d;
      rst_sync_n <= rst_sync_d;
    end
  end

  // ----------------------------------------
  // loss detection
  // ----------------------------------------
  drb_lost_detect u_detect (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .in_event(in_event),
    .in_busy(in_busy),
    .cnt_event(cnt_event),
    .cnt_busy(cnt_busy),
    .evt(evt)
  );

  // ----------------------------------------
  // hold state and interrupt pulse
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    irq_d = 1'b0;
    case (st_q)
      drb_pkg::drb_idle: begin
        if (evt.any_new) begin
          irq_d = 1'b1; // RQ11
          st_d = drb_pkg::drb_held; // RQ13
        end
      end
      drb_pkg::drb_held: begin
        if (evt.any_new) begin
          // a loss beside a release keeps the record held
          irq_d = 1'b1; // RQ11
        end else if (rec_release) begin
          st_d = drb_pkg::drb_idle; // RQ13
        end
      end
      default: begin
        st_d = drb_pkg::drb_idle;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_q <= drb_pkg::drb_idle;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------
  // record capture and merge
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      rec_d[i] = rec_q[i];
    end
    if (evt.any_new && (st_q == drb_pkg::drb_idle)) begin
      // first loss: snapshot the whole record
      for (int i = 0; i < 4; i++) begin
        rec_d[i] = basic_in[8 * i +: 8]; // RQ1
      end
      rec_d[3] = mark_lost(basic_in[31:24]); // RQ12
      rec_d[`DRB_OFS_CHTYPE] = type_byte(more_types); // RQ2 RQ3
      rec_d[`DRB_OFS_BITS_PER_CH] = `DRB_BITS_PER_CH; // RQ4
      rec_d[`DRB_OFS_CH_COUNT] = `DRB_CH_COUNT; // RQ5
      rec_d[`DRB_OFS_GROUP_ERR] = group_byte(group_err_in[3:0], group_err_in[7:4]); // RQ6
      for (int i = 8; i < 16; i++) begin
        rec_d[i] = lost_byte(4'(i), evt.in_lost, evt.cnt_lost); // RQ7
      end
    end else if (evt.any_new) begin
      // later losses merge; bytes 0 to 7 stay frozen
      rec_d[3] = mark_lost(rec_q[3]); // RQ12
      for (int i = 8; i < 16; i++) begin
        rec_d[i] = rec_q[i] | lost_byte(4'(i), evt.in_lost, evt.cnt_lost); // RQ7 RQ13
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 16; i++) begin
        rec_q[i] <= `DRB_RECORD_RESET;
      end
    end else begin
      for (int i = 0; i < 16; i++) begin
        rec_q[i] <= rec_d[i];
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_comb begin
    rd_d = rd_q;
    if (rd_en) begin
      rd_d = read_pick(rd_idx, rec_q); // RQ13
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  assign rd_data = rd_q;
  assign diag_irq = irq_q;
  assign rec_held = (st_q == drb_pkg::drb_held);
endmodule
`default_nettype wire

/* testbench/drb_record_props.sv */
/* assertions on drb_record ports.
   assumes: bound to drb_record; one clock. */
`timescale 1ns/10ps
`default_nettype none
module drb_record_props (
  // clock, reset, inputs
  input wire logic mclk,
  rst_n,
  rd_en,
  rec_release,
  input wire logic [15:0] in_event,
  in_busy,
  cnt_event,
  cnt_busy,
  input wire logic [3:0] rd_idx,
  // outputs
  input wire logic [7:0] rd_data,
  input wire logic diag_irq,
  rec_held
);
  // --
  // checks
  // --
  wire logic lost = |{in_event & in_busy, cnt_event & cnt_busy};
  wire logic held_rd = rd_en && rec_held;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_loss_irq: assert property (lost |-> ##2 diag_irq) else $error("late irq");
  chk_irq_cause: assert property (diag_irq |-> $past(lost, 2)) else $error("stray");
  chk_held_stays: assert property (rec_held && !rec_release |=> rec_held)
    else $error("dropped");
  chk_release_free: assert property (rec_held && rec_release && !$past(lost)
    && !$past(lost, 2) |=> !rec_held) else $error("stuck");
  chk_type_code: assert property (held_rd && rd_idx == 4'h4 |=> rd_data[6:0] == 7'h70)
    else $error("type");
  chk_fixed_counts: assert property (held_rd && rd_idx inside {4'h5, 4'h6}
    |=> rd_data == 8'h08) else $error("count");
  chk_odd_zero: assert property (rd_en && rd_idx[3] |=> (rd_data & 8'hAA) == 8'h00)
    else $error("odd bit");
  chk_lost_bit: assert property (held_rd && rd_idx == 4'h3 |=> rd_data[6])
    else $error("lost bit");
  cover property (diag_irq && $past(rec_held));
  cover property (rec_release && rec_held);
  cover property (rd_en && rd_idx == 4'hF);
endmodule
bind drb_record drb_record_props u_p (.mclk, .rst_n, .rd_en, .rec_release, .in_event,
  .in_busy, .cnt_event, .cnt_busy, .rd_idx, .rd_data, .diag_irq, .rec_held);
`default_nettype wire

/* testbench/drb_sw_model.sv */
/* software reader of the record.
   assumes: called on falling edges. */
`timescale 1ns/10ps
`default_nettype none
module drb_sw_model (
  // clock
  input wire logic mclk,
  // read port
  output logic rd_en,
  output logic [3:0] rd_idx,
  output logic rec_release
);
  // --
  // reader
  // --
  initial begin
    rd_en = 1'b0;
    rd_idx = 4'h0;
    rec_release = 1'b0;
  end
  task automatic read_all(input bit slow);
    for (int k = 0; k < 16; k++) begin
      rd_en = 1'b1;
      rd_idx = 4'(k);
      @(negedge mclk);
      if (slow) begin
        rd_en = 1'b0;
        rd_idx = ~rd_idx;
        @(negedge mclk);
      end
    end
    rd_en = 1'b0;
    rd_idx = ~rd_idx;
  endtask
  task automatic release_rec;
    rec_release = 1'b1;
    @(negedge mclk);
    rec_release = 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/drb_record_tb.sv */
/* bench of drb_record; read data checked from a queue.
   assumes: drb_sw_model does the reads. */
`timescale 1ns/10ps
`default_nettype none
module drb_record_tb;
  // --
  // bench
  // --
  logic mclk = 1'b0, rst_n = 1'b0, more_types = 1'b0, rd_pend = 1'b0;
  logic rd_en, rec_release, diag_irq, rec_held;
  logic [31:0] basic_in = 32'h0;
  logic [7:0] group_err_in = 8'h00;
  logic [7:0] rd_data;
  logic [3:0] rd_idx;
  logic [15:0] in_event = 16'h0, in_busy = 16'h0, cnt_event = 16'h0, cnt_busy = 16'h0;
  logic [15:0] li, lc;
  drb_pkg::drb_byte_t rec[16];
  drb_pkg::drb_byte_t exp_q[$];
  int miscompares = 0, n_tests = 0;
  always #10 mclk = ~mclk;
  drb_record u_dut (.mclk, .rst_n, .basic_in, .group_err_in, .more_types, .in_event,
    .in_busy, .cnt_event, .cnt_busy, .rd_en, .rd_idx, .rd_data, .rec_release, .diag_irq,
    .rec_held);
  drb_sw_model u_sw (.mclk, .rd_en, .rd_idx, .rec_release);
  task automatic check(input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) rd_pend <= rd_en;
  always @(negedge mclk)
    if (rd_pend)
      check(rd_data, exp_q.pop_front());
  function automatic drb_pkg::drb_byte_t spread(input logic [3:0] n);
    return {1'b0, n[3], 1'b0, n[2], 1'b0, n[1], 1'b0, n[0]};
  endfunction
  task automatic read_rec(input bit slow);
    for (int k = 0; k < 4; k++) begin
      rec[8 + k] = spread(li[4 * k +: 4]);
      rec[12 + k] = spread(lc[4 * k +: 4]);
    end
    foreach (rec[k])
      exp_q.push_back(rec[k]);
    u_sw.read_all(slow);
  endtask
  task automatic lose(input logic [15:0] i, c);
    in_busy = i;
    cnt_busy = c;
    in_event = i | 16'($urandom);
    cnt_event = c | 16'($urandom);
    li |= i;
    lc |= c;
    @(negedge mclk);
    in_event = 16'h0;
    cnt_event = 16'h0;
    @(negedge mclk);
    check({7'h00, diag_irq}, {7'h00, |{i, c}});
    check({7'h00, rec_held}, 8'h01);
    @(negedge mclk);
    check({7'h00, diag_irq}, 8'h00);
    @(negedge mclk);
  endtask
  initial begin
    void'($urandom(32'hFBEA));
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    for (int r = 0; r < 4; r++) begin
      basic_in = $urandom;
      group_err_in = 8'($urandom);
      more_types = r[0];
      li = 16'h0;
      lc = 16'h0;
      for (int k = 0; k < 4; k++)
        rec[k] = basic_in[8 * k +: 8];
      rec[3][6] = 1'b1;
      rec[4] = {more_types, 7'h70};
      rec[5] = 8'h08;
      rec[6] = 8'h08;
      rec[7] = group_err_in;
      lose(16'h1 << $urandom_range(15), 16'h1 << (5 * r));
      read_rec(r[1]);
      basic_in = ~basic_in;
      group_err_in = ~group_err_in;
      more_types = ~more_types;
      lose(16'($urandom), 16'($urandom));
      read_rec(1'b1);
      u_sw.release_rec();
      check({7'h00, rec_held}, 8'h00);
      repeat (2) @(negedge mclk);
      $display("round %0d done", r);
    end
    report_and_stop();
  end
  initial begin
    #100us;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
